// ==== design/eprt_pkg.sv ====
// Purpose: Shared constants for the page remove and tracking start block
// Assumes: Leaf codes, page types and error codes as used by the engine
// Notes: Error code values and type encodings are plain defaults
package eprt_pkg;

    // ------------------------------------------------------------
    // Leaf codes
    // ------------------------------------------------------------
    localparam logic [7:0] EPRT_LEAF_PAGE_REMOVE = 8'h03;
    localparam logic [7:0] EPRT_LEAF_TRACK_START = 8'h0C;

    // ------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------
    localparam int EPRT_ADDR_W = 64;
    localparam int EPRT_PAGE_OFS_W = 12;
    localparam logic [EPRT_PAGE_OFS_W-1:0] EPRT_PAGE_OFS_ZERO = 12'h000;

    // ------------------------------------------------------------
    // Page types
    // ------------------------------------------------------------
    localparam logic [2:0] EPRT_PT_CONTROL = 3'h0;
    localparam logic [2:0] EPRT_PT_THREAD_CONTROL = 3'h1;
    localparam logic [2:0] EPRT_PT_REGULAR = 3'h2;
    localparam logic [2:0] EPRT_PT_VERSION_ARRAY = 3'h3;
    localparam logic [2:0] EPRT_PT_TRIMMED = 3'h4;

    // ------------------------------------------------------------
    // Result codes
    // ------------------------------------------------------------
    localparam logic [63:0] EPRT_RES_OK = 64'h0;
    localparam logic [63:0] EPRT_ERR_CHILD_PRESENT = 64'h0000_0000_0000_000D;
    localparam logic [63:0] EPRT_ERR_ENCLAVE_ACTIVE = 64'h0000_0000_0000_000E;
    localparam logic [63:0] EPRT_ERR_PREV_TRACK_INCOMPLETE =
        64'h0000_0000_0000_0011;

    // ------------------------------------------------------------
    // Exit qualification codes
    // ------------------------------------------------------------
    localparam logic [1:0] EPRT_QUAL_PAGE_CONFLICT = 2'h0;
    localparam logic [1:0] EPRT_QUAL_TRACK_RESOURCE = 2'h1;
    localparam logic [1:0] EPRT_QUAL_TRACK_REFERENCE = 2'h2;

    // ------------------------------------------------------------
    // Outcome kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EPRT_OUT_RETURN,
        EPRT_OUT_GP_FAULT,
        EPRT_OUT_PAGE_FAULT,
        EPRT_OUT_VIRT_EXIT
    } eprt_outcome_t;

endpackage : eprt_pkg

// ==== design/eprt_checks.sv ====
// Purpose: Combinational check evaluation for one leaf request
// Assumes: Page state inputs describe the target page at request time
// Notes: Checks run in listed order; the first failure wins
`timescale 1ns/100ps
module eprt_checks (
    // Request
    input wire logic [7:0] leaf,
    input wire logic [eprt_pkg::EPRT_ADDR_W-1:0] page_addr,
    input wire logic guest_virt_en,
    // Page state
    input wire logic in_cache,
    input wire logic page_busy,
    input wire logic track_busy,
    input wire logic map_valid,
    input wire logic [2:0] page_type,
    input wire logic page_modified,
    input wire logic has_children,
    input wire logic [31:0] virtual_child_count,
    input wire logic threads_active,
    input wire logic tracking_pending,
    // Decision
    output eprt_pkg::eprt_outcome_t outcome,
    output logic [1:0] qual,
    output logic [63:0] result,
    output logic zero_flag,
    output logic invalidate,
    output logic track_start,
    output logic leaf_known
);
    import eprt_pkg::*;

    logic aligned;
    logic is_trim_clean;

    assign aligned = page_addr[EPRT_PAGE_OFS_W-1:0] == EPRT_PAGE_OFS_ZERO;
    assign is_trim_clean = page_type == EPRT_PT_TRIMMED && !page_modified;

    always_comb begin
        outcome = EPRT_OUT_RETURN;
        qual = EPRT_QUAL_PAGE_CONFLICT;
        result = EPRT_RES_OK;
        zero_flag = 1'b0;
        invalidate = 1'b0;
        track_start = 1'b0;
        leaf_known = 1'b1;
        if (leaf == EPRT_LEAF_PAGE_REMOVE) begin
            if (!aligned) begin
                outcome = EPRT_OUT_GP_FAULT;
            end else if (!in_cache) begin
                outcome = EPRT_OUT_PAGE_FAULT;
            end else if (page_busy) begin
                outcome = guest_virt_en ? EPRT_OUT_VIRT_EXIT
                                        : EPRT_OUT_GP_FAULT;
                qual = EPRT_QUAL_PAGE_CONFLICT;
            end else if (!map_valid || is_trim_clean) begin
                // Already unused: succeed with no change
                invalidate = 1'b0;
            end else if (page_type == EPRT_PT_VERSION_ARRAY) begin
                invalidate = 1'b1;
            end else if (page_type == EPRT_PT_CONTROL) begin
                if (has_children) begin
                    zero_flag = 1'b1;
                    result = EPRT_ERR_CHILD_PRESENT;
                end else if (guest_virt_en && virtual_child_count != 32'h0)
                begin
                    zero_flag = 1'b1;
                    result = EPRT_ERR_CHILD_PRESENT;
                end else begin
                    invalidate = 1'b1;
                end
            end else if (threads_active) begin
                zero_flag = 1'b1;
                result = EPRT_ERR_ENCLAVE_ACTIVE;
            end else if (page_type == EPRT_PT_REGULAR ||
                         page_type == EPRT_PT_THREAD_CONTROL ||
                         page_type == EPRT_PT_TRIMMED) begin
                invalidate = 1'b1;
            end
        end else if (leaf == EPRT_LEAF_TRACK_START) begin
            if (!aligned) begin
                outcome = EPRT_OUT_GP_FAULT;
            end else if (!in_cache) begin
                outcome = EPRT_OUT_PAGE_FAULT;
            end else if (track_busy) begin
                outcome = guest_virt_en ? EPRT_OUT_VIRT_EXIT
                                        : EPRT_OUT_GP_FAULT;
                qual = EPRT_QUAL_TRACK_RESOURCE;
            end else if (!map_valid || page_type != EPRT_PT_CONTROL) begin
                outcome = EPRT_OUT_PAGE_FAULT;
            end else if (tracking_pending) begin
                if (guest_virt_en) begin
                    outcome = EPRT_OUT_VIRT_EXIT;
                    qual = EPRT_QUAL_TRACK_REFERENCE;
                end
                zero_flag = 1'b1;
                result = EPRT_ERR_PREV_TRACK_INCOMPLETE;
            end else begin
                track_start = 1'b1;
            end
        end else begin
            leaf_known = 1'b0;
            outcome = EPRT_OUT_GP_FAULT;
        end
    end

endmodule : eprt_checks

// ==== design/eprt_engine.sv ====
// Purpose: Page remove and tracking start leaf engine
// Assumes: One request per req pulse; page state valid with the request
// Notes: Answer is registered one cycle after the request is taken
//
// How it works
// - Leaf 03H removes a page, detaching it and marking it unused.
// - Address not 4KByte aligned gives general protection fault, code 0.
// - Removal of an address outside the page cache gives a page fault.
// - Busy page: guest with extensions exits, else protection fault.
// - Invalid entry or clean trimmed page: succeed with no change.
// - Version-array page: clear valid, succeed.
// - Control page with children: zero flag, child-present error, stays valid.
// - Guest virtual child count non-zero counts as children; else invalidate.
// - Enclave threads active: zero flag, enclave-active error, no change.
// - Regular, thread control or trimmed page: clear valid, succeed.
// - Success writes result 0, clears zero flag; other flags always cleared.
// - Child-present means pages loaded; enclave-active means threads inside.
// - Leaf 0CH starts a tracking cycle on a control page.
// - Tracking address outside the page cache gives a page fault.
// - Tracking facility busy: guest exits, else protection fault.
// - Invalid entry or non-control page type gives a page fault.
// - Tracking pending: zero flag and error; a guest also exits in the same cycle.
// - Tracking success writes result 0 and clears the zero flag.
`timescale 1ns/100ps
module eprt_engine (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Request
    input wire logic req,
    input wire logic [7:0] leaf,
    input wire logic [eprt_pkg::EPRT_ADDR_W-1:0] count_register,
    input wire logic [eprt_pkg::EPRT_ADDR_W-1:0] guest_phys_addr,
    input wire logic [eprt_pkg::EPRT_ADDR_W-1:0] enclave_context_value,
    input wire logic guest_virt_en,
    // Page state
    input wire logic in_cache,
    input wire logic page_busy,
    input wire logic track_busy,
    input wire logic map_valid,
    input wire logic [2:0] page_type,
    input wire logic page_modified,
    input wire logic has_children,
    input wire logic [31:0] virtual_child_count,
    input wire logic threads_active,
    input wire logic tracking_pending,
    // Answer
    output logic done,
    output logic [63:0] result_register,
    output logic zero_flag,
    output logic carry_flag,
    output logic parity_flag,
    output logic aux_flag,
    output logic overflow_flag,
    output logic sign_flag,
    output logic gp_fault,
    output logic page_fault,
    output logic [eprt_pkg::EPRT_ADDR_W-1:0] fault_addr,
    output logic [31:0] fault_error,
    output logic virt_exit,
    output logic [1:0] exit_qual,
    output logic [eprt_pkg::EPRT_ADDR_W-1:0] exit_guest_phys,
    output logic [eprt_pkg::EPRT_ADDR_W-1:0] exit_guest_linear,
    // Page map updates
    output logic map_invalidate,
    output logic track_start
);
    import eprt_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic done;
        logic [63:0] result;
        logic zero;
        logic others;
        logic gp;
        logic pf;
        logic [EPRT_ADDR_W-1:0] faddr;
        logic vexit;
        logic [1:0] qual;
        logic [EPRT_ADDR_W-1:0] gpa;
        logic [EPRT_ADDR_W-1:0] gla;
        logic inval;
        logic track;
    } eprt_state_t;

    eprt_state_t st_r;
    eprt_state_t st_nxt;

    eprt_outcome_t outcome;
    logic [1:0] qual;
    logic [63:0] result;
    logic zero_dec;
    logic invalidate;
    logic trk;
    logic leaf_known;

    // ------------------------------------------------------------
    // Check evaluation
    // ------------------------------------------------------------
    eprt_checks u_checks (
        .leaf(leaf),
        .page_addr(count_register),
        .guest_virt_en(guest_virt_en),
        .in_cache(in_cache),
        .page_busy(page_busy),
        .track_busy(track_busy),
        .map_valid(map_valid),
        .page_type(page_type),
        .page_modified(page_modified),
        .has_children(has_children),
        .virtual_child_count(virtual_child_count),
        .threads_active(threads_active),
        .tracking_pending(tracking_pending),
        .outcome(outcome),
        .qual(qual),
        .result(result),
        .zero_flag(zero_dec),
        .invalidate(invalidate),
        .track_start(trk),
        .leaf_known(leaf_known)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.gp = 1'b0;
        st_nxt.pf = 1'b0;
        st_nxt.vexit = 1'b0;
        st_nxt.inval = 1'b0;
        st_nxt.track = 1'b0;
        if (req) begin
            st_nxt.done = 1'b1;
            unique case (outcome)
                EPRT_OUT_GP_FAULT: begin
                    st_nxt.gp = 1'b1;
                    st_nxt.faddr = count_register;
                end
                EPRT_OUT_PAGE_FAULT: begin
                    st_nxt.pf = 1'b1;
                    st_nxt.faddr = count_register;
                end
                EPRT_OUT_VIRT_EXIT: begin
                    st_nxt.vexit = 1'b1;
                    st_nxt.qual = qual;
                    if (leaf == EPRT_LEAF_PAGE_REMOVE) begin
                        st_nxt.gpa = guest_phys_addr;
                        st_nxt.gla = count_register;
                    end else begin
                        st_nxt.gpa = enclave_context_value;
                        st_nxt.gla = '0;
                    end
                end
                EPRT_OUT_RETURN: begin
                    st_nxt.result = result;
                    st_nxt.zero = zero_dec;
                    st_nxt.others = 1'b0;
                    st_nxt.inval = invalidate;
                    st_nxt.track = trk;
                end
            endcase
            // exit carries the pending flags as the guest resumes
            if (outcome == EPRT_OUT_VIRT_EXIT &&
                qual == EPRT_QUAL_TRACK_REFERENCE) begin
                st_nxt.result = result;
                st_nxt.zero = zero_dec;
                st_nxt.others = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign done = st_r.done;
    assign result_register = st_r.result;
    assign zero_flag = st_r.zero;
    assign carry_flag = st_r.others;
    assign parity_flag = st_r.others;
    assign aux_flag = st_r.others;
    assign overflow_flag = st_r.others;
    assign sign_flag = st_r.others;
    assign gp_fault = st_r.gp;
    assign page_fault = st_r.pf;
    assign fault_addr = st_r.faddr;
    assign fault_error = 32'h0000_0000;
    assign virt_exit = st_r.vexit;
    assign exit_qual = st_r.qual;
    assign exit_guest_phys = st_r.gpa;
    assign exit_guest_linear = st_r.gla;
    assign map_invalidate = st_r.inval;
    assign track_start = st_r.track;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic addr_aligned;

    assign addr_aligned =
        count_register[EPRT_PAGE_OFS_W-1:0] == EPRT_PAGE_OFS_ZERO;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || !clk_en);

    chk_misaligned_gp: assert property (
        req && !addr_aligned
        |=> gp_fault && !map_invalidate && !track_start)
        else $error("misaligned address did not fault");
    chk_remove_pf: assert property (
        req && leaf == EPRT_LEAF_PAGE_REMOVE && addr_aligned && !in_cache
        |=> page_fault && fault_addr == $past(count_register))
        else $error("remove outside cache did not page fault");
    chk_conflict_exit: assert property (
        req && leaf == EPRT_LEAF_PAGE_REMOVE && addr_aligned && in_cache
        && page_busy && guest_virt_en
        |=> virt_exit && exit_qual == EPRT_QUAL_PAGE_CONFLICT
        && exit_guest_phys == $past(guest_phys_addr)
        && exit_guest_linear == $past(count_register))
        else $error("page conflict exit wrong");
    chk_unused_keep: assert property (
        req && leaf == EPRT_LEAF_PAGE_REMOVE && addr_aligned && in_cache
        && !page_busy && !map_valid
        |=> !map_invalidate && !zero_flag && result_register == EPRT_RES_OK)
        else $error("unused page removal changed state");
    chk_child_keep: assert property (
        req && leaf == EPRT_LEAF_PAGE_REMOVE && addr_aligned && in_cache
        && !page_busy && map_valid && page_type == EPRT_PT_CONTROL
        && has_children
        |=> zero_flag && result_register == EPRT_ERR_CHILD_PRESENT
        && !map_invalidate)
        else $error("child present not reported");
    chk_active_err: assert property (
        req && leaf == EPRT_LEAF_PAGE_REMOVE && addr_aligned && in_cache
        && !page_busy && map_valid && page_type == EPRT_PT_REGULAR
        && threads_active
        |=> zero_flag && result_register == EPRT_ERR_ENCLAVE_ACTIVE
        && !map_invalidate)
        else $error("enclave active not reported");
    chk_remove_ok: assert property (
        map_invalidate |-> !zero_flag && result_register == EPRT_RES_OK
        && !gp_fault && !page_fault)
        else $error("invalidate without clean success");
    chk_track_exit: assert property (
        req && leaf == EPRT_LEAF_TRACK_START && addr_aligned && in_cache
        && track_busy && guest_virt_en
        |=> virt_exit && exit_qual == EPRT_QUAL_TRACK_RESOURCE
        && exit_guest_phys == $past(enclave_context_value)
        && exit_guest_linear == '0)
        else $error("tracking resource exit wrong");
    chk_track_pf: assert property (
        req && leaf == EPRT_LEAF_TRACK_START && addr_aligned && in_cache
        && !track_busy && !map_valid
        |=> page_fault && fault_addr == $past(count_register))
        else $error("invalid tracking page did not fault");
    chk_track_pend: assert property (
        req && leaf == EPRT_LEAF_TRACK_START && addr_aligned
        && in_cache && !track_busy && map_valid
        && page_type == EPRT_PT_CONTROL && tracking_pending
        |=> zero_flag && !track_start
        && result_register == EPRT_ERR_PREV_TRACK_INCOMPLETE)
        else $error("pending tracking not refused");
    chk_track_ok: assert property (
        track_start |-> $past(req) && !zero_flag && !carry_flag
        && result_register == EPRT_RES_OK)
        else $error("tracking start without success");
    chk_done_pulse: assert property (
        req |=> done ##1 (!done || $past(req)))
        else $error("done did not follow request");

    cov_remove_ok: cover property (map_invalidate);
    cov_track_ok: cover property (track_start);
    cov_exit: cover property (virt_exit);
    cov_fault: cover property (page_fault);
    cov_unknown_leaf: cover property (req && !leaf_known);

endmodule : eprt_engine

// ==== bench/eprt_sw_model.sv ====
// Purpose: Software side model that issues leaf requests
// Assumes: One request at a time; page state given with it
// Notes: Request fields are scrambled once the request is taken
`timescale 1ns/100ps
module eprt_sw_model (
    // Clock
    input wire logic sys_clk,
    // Request
    output logic req,
    output logic [7:0] leaf,
    output logic [63:0] count_register,
    // Page state
    output logic [8:0] st,
    output logic [2:0] page_type,
    output logic [31:0] virtual_child_count
);
    initial begin
        req = 1'b0;
        leaf = 8'h00;
        count_register = 64'h0;
        st = 9'h000;
        page_type = 3'h0;
        virtual_child_count = 32'h0;
    end

    task automatic issue(input logic [7:0] lf, input logic [63:0] a,
            input logic [8:0] s, input logic [2:0] t, input logic [31:0] v);
        @(posedge sys_clk);
        req <= 1'b1;
        leaf <= lf;
        count_register <= a;
        st <= s;
        page_type <= t;
        virtual_child_count <= v;
        @(posedge sys_clk);
        req <= 1'b0;
        leaf <= ~lf;
        count_register <= ~a;
    endtask : issue
endmodule : eprt_sw_model

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for the page remove and tracking engine
// Assumes: Answer one cycle after each request
// Notes: Expected outcomes are worked out here in check order
`timescale 1ns/100ps
module testbench;
    import eprt_pkg::*;
    localparam logic [8:0] IC = 9'h100, PB = 9'h080, TB = 9'h040,
        MV = 9'h020, PM = 9'h010, HC = 9'h008, TA = 9'h004,
        TP = 9'h002, GV = 9'h001;
    localparam logic [2:0] CP = EPRT_PT_CONTROL,
        TC = EPRT_PT_THREAD_CONTROL, RG = EPRT_PT_REGULAR,
        VA = EPRT_PT_VERSION_ARRAY, TR = EPRT_PT_TRIMMED;
    localparam logic [7:0] RM = EPRT_LEAF_PAGE_REMOVE;
    localparam logic [7:0] TK = EPRT_LEAF_TRACK_START;
    localparam logic [63:0] A = 64'h0000_0000_0040_3000;
    localparam logic [63:0] GPA = 64'h0000_0000_0912_3000;
    localparam logic [63:0] ECV = 64'h0000_0000_0ABC_0000;
    logic sys_clk = 1'b0, rst, clk_en, req, zero, gp, pf, vx, inv, trk, done;
    logic [7:0] leaf;
    logic [8:0] st;
    logic [2:0] pt;
    logic [31:0] vcc, ferr;
    logic [4:0] flg;
    logic [1:0] exq;
    logic [63:0] cnt, gpa, ecv, res, faddr, ephys, elin;
    int err_count = 0, checks = 0, cycles = 0;

    always #4 sys_clk = ~sys_clk;

    eprt_sw_model sw (.sys_clk(sys_clk), .req(req), .leaf(leaf),
        .count_register(cnt), .st(st), .page_type(pt),
        .virtual_child_count(vcc));

    eprt_engine dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .req(req), .leaf(leaf), .count_register(cnt),
        .guest_phys_addr(gpa), .enclave_context_value(ecv),
        .guest_virt_en(st[0]), .in_cache(st[8]), .page_busy(st[7]),
        .track_busy(st[6]), .map_valid(st[5]), .page_type(pt),
        .page_modified(st[4]), .has_children(st[3]),
        .virtual_child_count(vcc), .threads_active(st[2]),
        .tracking_pending(st[1]), .done(done), .result_register(res),
        .zero_flag(zero), .carry_flag(flg[4]), .parity_flag(flg[3]),
        .aux_flag(flg[2]), .overflow_flag(flg[1]), .sign_flag(flg[0]),
        .gp_fault(gp), .page_fault(pf), .fault_addr(faddr),
        .fault_error(ferr), .virt_exit(vx), .exit_qual(exq),
        .exit_guest_phys(ephys), .exit_guest_linear(elin),
        .map_invalidate(inv), .track_start(trk));

    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic cmp(input string nm, input logic [63:0] e,
            input logic [63:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic run(input logic [7:0] lf, input logic [63:0] a,
            input logic [8:0] s, input logic [2:0] t, input logic [31:0] v);
        eprt_outcome_t ek;
        logic [63:0] er, ep, el;
        logic ez, ei, et, ew;
        logic [1:0] eq;
        int n;
        ek = EPRT_OUT_RETURN;
        er = 64'h0;
        ep = 64'h0;
        el = 64'h0;
        ez = 1'b0;
        ei = 1'b0;
        et = 1'b0;
        eq = 2'h0;
        if (lf != RM && lf != TK) begin
            ek = EPRT_OUT_GP_FAULT;
        end else if (a[EPRT_PAGE_OFS_W-1:0] != EPRT_PAGE_OFS_ZERO) begin
            ek = EPRT_OUT_GP_FAULT;
        end else if (!s[8]) begin
            ek = EPRT_OUT_PAGE_FAULT;
        end else if (lf == RM) begin
            if (s[7]) begin
                ek = s[0] ? EPRT_OUT_VIRT_EXIT : EPRT_OUT_GP_FAULT;
                eq = EPRT_QUAL_PAGE_CONFLICT;
                ep = GPA;
                el = a;
            end else if (!s[5] || (t == TR && !s[4])) begin
                ei = 1'b0;
            end else if (t == VA) begin
                ei = 1'b1;
            end else if (t == CP) begin
                ez = s[3] || (s[0] && v != 32'h0);
                er = ez ? EPRT_ERR_CHILD_PRESENT : 64'h0;
                ei = !ez;
            end else if (s[2]) begin
                ez = 1'b1;
                er = EPRT_ERR_ENCLAVE_ACTIVE;
            end else begin
                ei = (t == RG || t == TC || t == TR);
            end
        end else if (s[6]) begin
            ek = s[0] ? EPRT_OUT_VIRT_EXIT : EPRT_OUT_GP_FAULT;
            eq = EPRT_QUAL_TRACK_RESOURCE;
            ep = ECV;
        end else if (!s[5] || t != CP) begin
            ek = EPRT_OUT_PAGE_FAULT;
        end else if (s[1]) begin
            ek = s[0] ? EPRT_OUT_VIRT_EXIT : EPRT_OUT_RETURN;
            eq = EPRT_QUAL_TRACK_REFERENCE;
            ep = ECV;
            ez = 1'b1;
            er = EPRT_ERR_PREV_TRACK_INCOMPLETE;
        end else begin
            et = 1'b1;
        end
        ew = ek == EPRT_OUT_RETURN || ez && lf == TK;
        sw.issue(lf, a, s, t, v);
        n = 0;
        @(negedge sys_clk);
        while (done !== 1'b1 && n < 4) begin
            @(negedge sys_clk);
            n++;
        end
        cmp("done", 64'h1, {63'h0, done});
        cmp("gp_fault", {63'h0, ek == EPRT_OUT_GP_FAULT}, {63'h0, gp});
        cmp("page_fault", {63'h0, ek == EPRT_OUT_PAGE_FAULT}, {63'h0, pf});
        cmp("virt_exit", {63'h0, ek == EPRT_OUT_VIRT_EXIT}, {63'h0, vx});
        cmp("invalidate", {63'h0, ei}, {63'h0, inv});
        cmp("track_start", {63'h0, et}, {63'h0, trk});
        if (ew) begin
            cmp("result", er, res);
            cmp("zero_flag", {63'h0, ez}, {63'h0, zero});
            cmp("flags", 64'h0, {59'h0, flg});
        end
        if (ek == EPRT_OUT_PAGE_FAULT) cmp("fault_addr", a, faddr);
        if (ek == EPRT_OUT_GP_FAULT) cmp("fault_error", 64'h0, {32'h0, ferr});
        if (ek == EPRT_OUT_VIRT_EXIT) begin
            cmp("exit_qual", {62'h0, eq}, {62'h0, exq});
            cmp("exit_phys", ep, ephys);
            cmp("exit_linear", el, elin);
        end
        @(negedge sys_clk);
        cmp("done_after", 64'h0, {63'h0, done});
        cmp("inval_after", 64'h0, {63'h0, inv});
    endtask : run

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            err_count++;
            results();
        end
    end

    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        gpa = GPA;
        ecv = ECV;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        cmp("reset_done", 64'h0, {63'h0, done});
        // Frozen clock enable: a request must not be taken
        @(posedge sys_clk);
        clk_en <= 1'b0;
        sw.issue(RM, A, IC | MV, RG, 32'h0);
        @(negedge sys_clk);
        cmp("frozen_done", 64'h0, {63'h0, done});
        cmp("frozen_inval", 64'h0, {63'h0, inv});
        @(posedge sys_clk);
        clk_en <= 1'b1;
        @(negedge sys_clk);
        cmp("thawed_done", 64'h0, {63'h0, done});
        cmp("thawed_inval", 64'h0, {63'h0, inv});
        run(RM, A, IC | MV, RG, 32'h0);
        run(RM, A, IC | MV | PM, TC, 32'h0);
        run(RM, A, IC | MV | PM, TR, 32'h0);
        run(RM, A, IC | MV, TR, 32'h0);
        run(RM, A, IC | TA, RG, 32'h0);
        run(RM, A, IC | MV | TA, VA, 32'h0);
        run(RM, A, IC | MV | HC, CP, 32'h0);
        run(RM, A, IC | MV | GV, CP, 32'h1);
        run(RM, A, IC | MV, CP, 32'h1);
        run(RM, A, IC | MV | TA | PM, TR, 32'h0);
        run(RM, A | 64'h800, PB, RG, 32'h0);
        run(RM, A, MV, RG, 32'h0);
        run(RM, A, IC | PB | MV, RG, 32'h0);
        run(RM, A, IC | PB | GV, RG, 32'h0);
        run(TK, A, IC | MV, CP, 32'h0);
        run(TK, A | 64'h001, IC | MV, CP, 32'h0);
        run(TK, A, TB, CP, 32'h0);
        run(TK, A, IC | TB | GV | TP, CP, 32'h0);
        run(TK, A, IC | TB, CP, 32'h0);
        run(TK, A, IC | TP, CP, 32'h0);
        run(TK, A, IC | MV, RG, 32'h0);
        run(TK, A, IC | MV | TP, CP, 32'h0);
        run(TK, A, IC | MV | TP | GV, CP, 32'h0);
        run(TK, A, IC | MV | GV, CP, 32'h0);
        run(8'h05, A, IC | MV, RG, 32'h0);
        results();
    end
endmodule : testbench
